// >>> logic/popx_pkg.sv
// Package with opcodes, widths, reset values and carrier types of the port and power-off decoder.
// Notes on behaviour
// - Port-two output opcode copies accumulator to output port two in one cycle.
// - OR opcode ORs accumulator with pointed memory nibble into accumulator, carry kept.
// - First power-off opcode enters clock operating mode when armed just before.
// - Second power-off opcode enters RAM back-up mode when armed just before.
// - No-operation only advances program counter by one and clears the arming flag.
package popx_pkg;
  localparam int          NIB_W          = 4;
  localparam int          OP_W           = 10;
  localparam int          PC_W           = 14;
  localparam logic [9:0]  OP_PORT_TWO    = 10'h222;
  localparam logic [9:0]  OP_OR_MEM      = 10'h019;
  localparam logic [9:0]  OP_CLOCK_OFF   = 10'h002;
  localparam logic [9:0]  OP_RAM_OFF     = 10'h008;
  // Arming opcode is not fixed here; the default value is arbitrary.
  localparam logic [9:0]  OP_ARM_DEFAULT = 10'h05b;
  localparam logic [3:0]  NIB_RESET      = 4'h0;
  localparam logic [13:0] PC_RESET       = 14'h0000;
  localparam logic [13:0] PC_STEP        = 14'h0001;

  typedef enum logic [2:0] {
    POPX_RUN        = 3'b001,
    POPX_CLOCK_MODE = 3'b010,
    POPX_RAM_BACKUP = 3'b100
  } popx_mode_type;

  typedef struct packed {
    logic        valid;
    logic [9:0]  opcode;
    logic [3:0]  mem_nibble;
  } popx_instr_type;
endpackage

// >>> logic/popx_decode.sv
// Combinational opcode decoder of the port and power-off instructions.
`timescale 1ns/10ps
module popx_decode
  import popx_pkg::*;
#(
  parameter logic [9:0] OP_ARM = OP_ARM_DEFAULT
) (
  input  wire logic [9:0] opcode,
  output logic            is_port_two,
  output logic            is_or_mem,
  output logic            is_clock_off,
  output logic            is_ram_off,
  output logic            is_arm
);
  always_comb begin
    is_port_two  = (opcode == OP_PORT_TWO);
    is_or_mem    = (opcode == OP_OR_MEM);
    is_clock_off = (opcode == OP_CLOCK_OFF);
    is_ram_off   = (opcode == OP_RAM_OFF);
    is_arm       = (opcode == OP_ARM);
  end
endmodule

// >>> logic/popx_exec.sv
// Execution unit of the port-two output, OR, arming and power-off instructions.
`timescale 1ns/10ps
module popx_exec
  import popx_pkg::*;
#(
  parameter logic [9:0] OP_ARM = OP_ARM_DEFAULT
) (
  input  wire logic           clock,
  input  wire logic           rst,
  input  wire logic           clk_en,
  input  wire popx_instr_type instr,
  output logic [3:0]          output_port_two,
  output logic [3:0]          acc,
  output logic                carry_flag,
  output logic [13:0]         pc,
  output logic                arm_flag,
  output logic                clock_mode,
  output logic                ram_backup
);
  logic [3:0]    acc_q;
  logic [3:0]    acc_d;
  logic [3:0]    port_q;
  logic [13:0]   pc_q;
  logic          arm_q;
  logic          carry_q;
  popx_mode_type mode_q;
  popx_mode_type mode_d;
  logic          clock_mode_q;
  logic          ram_backup_q;
  logic          is_port_two;
  logic          is_or_mem;
  logic          is_clock_off;
  logic          is_ram_off;
  logic          is_arm;
  logic          step;

  popx_decode #(.OP_ARM(OP_ARM)) u_decode (
    .opcode       (instr.opcode),
    .is_port_two  (is_port_two),
    .is_or_mem    (is_or_mem),
    .is_clock_off (is_clock_off),
    .is_ram_off   (is_ram_off),
    .is_arm       (is_arm)
  );

  // Instructions run only while the core is awake and enabled.
  assign step = clk_en && instr.valid && (mode_q == POPX_RUN);

  always_comb begin
    acc_d = acc_q;
    if (is_or_mem) begin
      acc_d = acc_q | instr.mem_nibble;
    end
  end

  always_comb begin
    mode_d = mode_q;
    if (arm_q && is_clock_off) begin
      mode_d = POPX_CLOCK_MODE;
    end else if (arm_q && is_ram_off) begin
      mode_d = POPX_RAM_BACKUP;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      acc_q <= NIB_RESET;
    end else if (step) begin
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      port_q <= NIB_RESET;
    end else if (step && is_port_two) begin
      port_q <= acc_q;
    end
  end

  // Carry is held by this unit only to show that none of these opcodes touch it.
  always_ff @(posedge clock) begin
    if (rst) begin
      carry_q <= 1'b0;
    end else begin
      carry_q <= carry_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pc_q <= PC_RESET;
    end else if (step) begin
      pc_q <= pc_q + PC_STEP;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      arm_q <= 1'b0;
    end else if (step) begin
      arm_q <= is_arm;
    end
  end

  // Without arming, mode_d keeps mode_q, so a power-off opcode is a plain step.
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q <= POPX_RUN;
    end else if (step) begin
      mode_q <= mode_d;
    end
  end

  // The mode outputs have flip-flops of their own so that no decode sits before the pins.
  always_ff @(posedge clock) begin
    if (rst) begin
      clock_mode_q <= 1'b0;
    end else if (step) begin
      clock_mode_q <= (mode_d == POPX_CLOCK_MODE);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ram_backup_q <= 1'b0;
    end else if (step) begin
      ram_backup_q <= (mode_d == POPX_RAM_BACKUP);
    end
  end

  assign output_port_two = port_q;
  assign acc             = acc_q;
  assign carry_flag      = carry_q;
  assign pc              = pc_q;
  assign arm_flag        = arm_q;
  assign clock_mode      = clock_mode_q;
  assign ram_backup      = ram_backup_q;

  port_two_a: assert property (
    @(posedge clock) disable iff (rst)
    step && is_port_two |=> output_port_two == $past(acc_q))
    else $error("port two did not take the accumulator");

  port_kept_a: assert property (
    @(posedge clock) disable iff (rst)
    step && !is_port_two |=> $stable(port_q))
    else $error("port two changed without its opcode");

  or_result_a: assert property (
    @(posedge clock) disable iff (rst)
    step && is_or_mem |=> acc_q == ($past(acc_q) | $past(instr.mem_nibble)))
    else $error("accumulator OR result wrong");

  acc_kept_a: assert property (
    @(posedge clock) disable iff (rst)
    step && !is_or_mem |=> $stable(acc_q))
    else $error("accumulator changed without the OR opcode");

  clock_mode_a: assert property (
    @(posedge clock) disable iff (rst)
    step && arm_q && is_clock_off |=> clock_mode)
    else $error("armed clock-mode power-off not taken");

  clock_flag_a: assert property (
    @(posedge clock) disable iff (rst)
    clock_mode == (mode_q == POPX_CLOCK_MODE))
    else $error("clock mode output disagrees with the mode state");

  ram_backup_a: assert property (
    @(posedge clock) disable iff (rst)
    step && arm_q && is_ram_off |=> ram_backup)
    else $error("armed RAM back-up power-off not taken");

  ram_flag_a: assert property (
    @(posedge clock) disable iff (rst)
    ram_backup == (mode_q == POPX_RAM_BACKUP))
    else $error("RAM back-up output disagrees with the mode state");

  sleep_holds_a: assert property (
    @(posedge clock) disable iff (rst)
    mode_q != POPX_RUN |=> $stable(mode_q) && $stable(pc_q) && $stable(acc_q))
    else $error("state moved in a power-off mode");

  unarmed_nop_a: assert property (
    @(posedge clock) disable iff (rst)
    step && !arm_q && (is_clock_off || is_ram_off) |=> mode_q == POPX_RUN && $stable(acc_q))
    else $error("unarmed power-off changed state");

  unarmed_port_a: assert property (
    @(posedge clock) disable iff (rst)
    step && !arm_q && (is_clock_off || is_ram_off) |=> $stable(port_q) && !arm_q)
    else $error("unarmed power-off touched port or arming flag");

  pc_step_a: assert property (
    @(posedge clock) disable iff (rst)
    step |=> pc_q == $past(pc_q) + PC_STEP)
    else $error("program counter did not advance by one");

  carry_kept_a: assert property (
    @(posedge clock) disable iff (rst)
    step |=> $stable(carry_q))
    else $error("carry changed");

  arm_set_a: assert property (
    @(posedge clock) disable iff (rst)
    step && is_arm |=> arm_q)
    else $error("arming instruction did not set the flag");

  arm_oneshot_a: assert property (
    @(posedge clock) disable iff (rst)
    step ##1 (step && !is_arm) |=> !arm_q)
    else $error("arming flag outlived one instruction");

  frozen_a: assert property (
    @(posedge clock) disable iff (rst)
    !clk_en |=> $stable(pc_q) && $stable(port_q) && $stable(acc_q) && $stable(arm_q))
    else $error("state moved while clock enable low");

  reset_state_a: assert property (
    @(posedge clock)
    rst |=> pc_q == PC_RESET && acc_q == NIB_RESET && mode_q == POPX_RUN && !arm_q)
    else $error("state not cleared by reset");

  cov_port_c: cover property (@(posedge clock) step && is_port_two);
  cov_or_c: cover property (@(posedge clock) step && is_or_mem);
  cov_clock_c: cover property (@(posedge clock) step && arm_q && is_clock_off);
  cov_ram_c: cover property (@(posedge clock) step && arm_q && is_ram_off);
  cov_nop_c: cover property (@(posedge clock) step && !arm_q && is_ram_off);
endmodule

// >>> bench/popx_port_load.sv
// Model of the external load that latches the pins of output port two.
`timescale 1ns/10ps
module popx_port_load (
  input  wire logic       clock,
  input  wire logic [3:0] output_port_two,
  output logic [3:0]      seen_q
);
  always_ff @(posedge clock) begin
    seen_q <= output_port_two;
  end
endmodule

// >>> bench/test_port_or_powerdown_instr_exec.sv
// Testbench of the port-two output, OR and power-off execution unit.
`timescale 1ns/10ps
module test_port_or_powerdown_instr_exec
  import popx_pkg::*;
;
  logic           clock = 1'b0;
  logic           rst = 1'b1;
  logic           clk_en = 1'b0;
  popx_instr_type instr = '0;
  logic [3:0]     port;
  logic [3:0]     acc;
  logic           carry;
  logic [13:0]    pc;
  logic           arm;
  logic           cmode;
  logic           rbak;
  logic [3:0]     seen;
  int             n_fail = 0;
  int             compares = 0;
  logic [29:0]    rows [9];

  always #12.5 clock = ~clock;

  popx_exec popx_exec_inst (.clock(clock), .rst(rst), .clk_en(clk_en), .instr(instr),
    .output_port_two(port), .acc(acc), .carry_flag(carry), .pc(pc), .arm_flag(arm),
    .clock_mode(cmode), .ram_backup(rbak));
  popx_port_load popx_port_load_inst (.clock(clock), .output_port_two(port), .seen_q(seen));

  // Packs the visible state as acc, port, arm, clock mode, backup, carry, pc low nibble.
  function automatic logic [15:0] st();
    return {acc, port, arm, cmode, rbak, carry, pc[3:0]};
  endfunction

  task check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t state %h expected %h", $time, got, exp);
    end
  endtask

  task end_sim;
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task run(input logic [9:0] op, input logic [3:0] nib, input logic en);
    instr = '{1'b1, op, nib};
    clk_en = en;
    @(posedge clock);
    #2;
  endtask

  initial begin
    rows = '{
      {OP_OR_MEM, 4'h5, 16'h5001}, {OP_PORT_TWO, 4'h0, 16'h5502},
      {OP_OR_MEM, 4'ha, 16'hf503}, {OP_PORT_TWO, 4'h3, 16'hff04},
      {OP_CLOCK_OFF, 4'h0, 16'hff05}, {OP_RAM_OFF, 4'h0, 16'hff06},
      {OP_ARM_DEFAULT, 4'h0, 16'hff87}, {OP_OR_MEM, 4'h0, 16'hff08},
      {OP_RAM_OFF, 4'h0, 16'hff09}};
    repeat (16) @(posedge clock);
    #2;
    rst = 1'b0;
    clk_en = 1'b1;
    check(st(), 16'h0000);
    foreach (rows[i]) begin
      run(rows[i][29:20], rows[i][19:16], 1'b1);
      check(st(), rows[i][15:0]);
    end
    run(OP_OR_MEM, 4'h0, 1'b0);
    check(st(), 16'hff09);
    check({12'h000, seen}, 16'h000f);
    run(OP_ARM_DEFAULT, 4'h0, 1'b1);
    run(OP_RAM_OFF, 4'h0, 1'b1);
    check(st(), 16'hff2b);
    run(OP_PORT_TWO, 4'h0, 1'b1);
    check(st(), 16'hff2b);
    rst = 1'b1;
    @(posedge clock);
    #2;
    rst = 1'b0;
    check(st(), 16'h0000);
    run(OP_ARM_DEFAULT, 4'h0, 1'b1);
    run(OP_CLOCK_OFF, 4'h0, 1'b1);
    check(st(), 16'h0042);
    check({2'b00, pc}, 16'h0002);
    end_sim();
  end
endmodule
